// File: rtl/adc_cmp_pkg.sv
// Shared constants for the converter and comparator control block
package adc_cmp_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] RESULT_LOW_OFS = 8'h04;
  localparam logic [7:0] RESULT_HIGH_OFS = 8'h05;
  localparam logic [7:0] CONV_CTRL_OFS = 8'h06;
  localparam logic [7:0] CHAN_SEL_OFS = 8'h07;
  localparam logic [7:0] CMP_CTRL_OFS = 8'h08;

  // converter_control_reg fields
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_START_BIT = 6;
  localparam int CTL_FREE_BIT = 5;
  localparam int CTL_DONE_BIT = 4;
  localparam int CTL_IE_BIT = 3;
  localparam int CTL_PS_HI = 2;
  localparam int CTL_PS_LO = 0;

  // channel_select_reg fields
  localparam int CHAN_REF_HI = 7;
  localparam int CHAN_REF_LO = 6;
  localparam int CHAN_LEFT_BIT = 5;
  localparam int CHAN_TOP_BIT = 4;
  localparam int CHAN_LOW_HI = 3;

  // comparator_control_status fields
  localparam int CMP_OFF_BIT = 7;
  localparam int CMP_BG_BIT = 6;
  localparam int CMP_OUT_BIT = 5;
  localparam int CMP_FLAG_BIT = 4;
  localparam int CMP_IE_BIT = 3;
  localparam int CMP_MUX_BIT = 2;
  localparam int CMP_EDGE_HI = 1;
  localparam int CMP_EDGE_LO = 0;

  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;

  // Edge mode codes
  localparam logic [1:0] EDGE_TOGGLE = 2'h0;
  localparam logic [1:0] EDGE_RESERVED = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h3;

  // Converter timing in converter clock cycles
  localparam logic [4:0] NORMAL_CYCLES = 5'h0d;
  localparam logic [4:0] EXT_CYCLES = 5'h19;
  localparam logic [4:0] NORMAL_SH_CYCLE = 5'h01;
  localparam logic [4:0] EXT_SH_CYCLE = 5'h0d;

  // Channel codes from here upward count as differential pairs
  localparam logic [4:0] DIFF_FIRST_CODE = 5'h0b;
endpackage

// File: rtl/conv_clock_div.sv
// Converter clock prescaler with rising and falling edge ticks
`timescale 1ns/100ps
module conv_clock_div
  import adc_cmp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic run, // converter enable
  input wire logic [2:0] ratio_sel, // prescale_select
  output logic rise_tick, // converter clock rising edge
  output logic fall_tick, // converter clock falling edge
  output logic conv_clk // divided clock level
);
  typedef struct packed {
    logic [6:0] cnt;
    logic rise;
    logic fall;
    logic lvl;
  } div_t;

  div_t q;
  div_t n;
  logic [7:0] ratio;

  // Ratios 2,2,4,8,...,128
  function automatic logic [7:0] div_ratio(input logic [2:0] sel);
    return (sel == 3'h0) ? 8'h02 : (8'h01 << sel);
  endfunction

  always_comb begin
    n = q;
    ratio = div_ratio(ratio_sel);
    n.rise = 1'b0;
    n.fall = 1'b0;
    if (!run) begin
      // Held in reset while the converter is off
      n = '0;
    end else begin
      n.cnt = q.cnt + 7'h01;
      if (q.cnt == 7'(ratio - 8'h01)) begin
        n.cnt = 7'h00;
        n.rise = 1'b1;
        n.lvl = 1'b1;
      end else if (q.cnt == 7'((ratio >> 1) - 8'h01)) begin
        n.fall = 1'b1;
        n.lvl = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign rise_tick = q.rise;
  assign fall_tick = q.fall;
  assign conv_clk = q.lvl;
endmodule

// File: rtl/adc_cmp_ctrl.sv
// Converter sequencing, result registers and analog comparator control
`timescale 1ns/100ps
module adc_cmp_ctrl
  import adc_cmp_pkg::*;
(
  input wire logic clk, // system clock, 125 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic gie, // processor global interrupt enable
  input wire logic cmp_vec_ack, // comparator vector taken
  input wire logic conv_vec_ack, // conversion vector taken
  input wire logic cmp_raw, // analog comparator output
  input wire logic [9:0] conv_data, // successive approximation result
  output logic cmp_irq, // comparator interrupt request
  output logic conv_irq, // conversion interrupt request
  output logic cmp_power_off, // comparator switched off
  output logic cmp_bandgap, // bandgap on positive input
  output logic cmp_neg_from_mux, // negative input from channel mux
  output logic [3:0] cmp_neg_chan, // channel for negative input
  output logic pin_change_block, // mask pin-change on comparator pins
  output logic conv_power, // converter powered
  output logic conv_clk, // converter clock
  output logic [4:0] conv_chan, // buffered channel select
  output logic [1:0] conv_ref, // buffered reference select
  output logic sample_hold, // sample-and-hold strobe
  output logic conv_busy, // conversion in progress
  output logic conv_done // conversion completed pulse
);
  typedef enum logic [0:0] {IDLE, BUSY} phase_t;

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] chan;
    logic [7:0] cmp;
    logic [7:0] rdata;
    logic [9:0] res;
    logic lock;
    logic [4:0] chan_buf;
    logic [1:0] ref_buf;
    phase_t phase;
    logic busy;
    logic [4:0] cyc;
    logic warm;
    logic parity;
    logic s1;
    logic s2;
    logic prev;
    logic cmp_irq;
    logic conv_irq;
    logic neg_mux;
    logic [3:0] neg_chan;
    logic pcblk;
    logic sh;
    logic done;
  } state_t;

  state_t q;
  state_t n;
  logic rise;
  logic fall;
  logic cmp_evt;
  logic conv_evt;
  logic last;
  logic wr_ctl;
  logic wr_cmp;

  function automatic logic [4:0] conv_len(input logic warm);
    return warm ? NORMAL_CYCLES : EXT_CYCLES;
  endfunction

  function automatic logic [4:0] sh_cycle(input logic warm);
    return warm ? NORMAL_SH_CYCLE : EXT_SH_CYCLE;
  endfunction

  function automatic logic is_diff(input logic [4:0] ch);
    return ch >= DIFF_FIRST_CODE;
  endfunction

  // Alignment applied at read time so the left bit acts at once
  function automatic logic [7:0] align(input logic [9:0] r,
                                       input logic left,
                                       input logic hi);
    if (hi) begin
      return left ? r[9:2] : {6'h00, r[9:8]};
    end
    return left ? {r[1:0], 6'h00} : r[7:0];
  endfunction

  conv_clock_div conv_clock_div_i (
    .clk(clk),
    .rst_n(rst_n),
    .run(q.ctl[CTL_EN_BIT]),
    .ratio_sel(q.ctl[CTL_PS_HI:CTL_PS_LO]),
    .rise_tick(rise),
    .fall_tick(fall),
    .conv_clk(conv_clk)
  );

  always_comb begin
    n = q;
    n.sh = 1'b0;
    n.done = 1'b0;
    cmp_evt = 1'b0;
    conv_evt = 1'b0;
    last = 1'b0;
    wr_ctl = wr && addr == CONV_CTRL_OFS;
    wr_cmp = wr && addr == CMP_CTRL_OFS;

    // Two-stage synchroniser; only s2 and prev feed logic
    n.s1 = cmp_raw;
    n.s2 = q.s1;
    n.prev = q.s2;
    if (!q.cmp[CMP_OFF_BIT] && q.s2 != q.prev) begin
      unique case (q.cmp[CMP_EDGE_HI:CMP_EDGE_LO])
        EDGE_TOGGLE: cmp_evt = 1'b1;
        EDGE_RESERVED: cmp_evt = 1'b0;
        EDGE_FALL: cmp_evt = !q.s2;
        EDGE_RISE: cmp_evt = q.s2;
      endcase
    end

    if (!q.ctl[CTL_EN_BIT]) begin
      // Fully idle; next conversion will be the extended one
      n.phase = IDLE;
      n.busy = 1'b0;
      n.cyc = 5'h00;
      n.warm = 1'b0;
      n.parity = 1'b0;
      n.ctl[CTL_START_BIT] = 1'b0;
    end else begin
      last = q.busy && q.cyc == conv_len(q.warm) - 5'h01;
      if (!q.busy || last) begin
        n.chan_buf = q.chan[CHAN_TOP_BIT:0];
        n.ref_buf = q.chan[CHAN_REF_HI:CHAN_REF_LO];
      end
      if (rise) begin
        n.parity = !q.parity;
      end
      if (fall && q.busy && q.cyc == sh_cycle(q.warm)) begin
        n.sh = 1'b1;
      end
      if (rise) begin
        unique case (q.phase)
          IDLE: begin
            if (q.ctl[CTL_START_BIT] &&
                !(is_diff(q.chan_buf) && q.parity)) begin
              n.phase = BUSY;
              n.busy = 1'b1;
              n.cyc = 5'h00;
            end
          end
          BUSY: begin
            if (last) begin
              conv_evt = 1'b1;
              n.done = 1'b1;
              n.warm = 1'b1;
              n.cyc = 5'h00;
              if (!q.lock) begin
                n.res = conv_data;
              end
              if (!q.ctl[CTL_FREE_BIT]) begin
                n.phase = IDLE;
                n.busy = 1'b0;
                n.ctl[CTL_START_BIT] = 1'b0;
              end
            end else begin
              n.cyc = q.cyc + 5'h01;
            end
          end
        endcase
      end
    end

    // Register writes; a start write wins over the hardware clear
    if (wr_ctl) begin
      n.ctl[CTL_EN_BIT] = wdata[CTL_EN_BIT];
      n.ctl[CTL_FREE_BIT] = wdata[CTL_FREE_BIT];
      n.ctl[CTL_IE_BIT] = wdata[CTL_IE_BIT];
      n.ctl[CTL_PS_HI:CTL_PS_LO] = wdata[CTL_PS_HI:CTL_PS_LO];
      if (!wdata[CTL_EN_BIT]) begin
        n.ctl[CTL_START_BIT] = 1'b0;
      end else if (wdata[CTL_START_BIT]) begin
        n.ctl[CTL_START_BIT] = 1'b1;
      end
    end
    if (wr && addr == CHAN_SEL_OFS) begin
      n.chan = wdata;
    end
    if (wr_cmp) begin
      n.cmp[CMP_OFF_BIT:CMP_BG_BIT] = wdata[CMP_OFF_BIT:CMP_BG_BIT];
      n.cmp[CMP_IE_BIT:CMP_EDGE_LO] = wdata[CMP_IE_BIT:CMP_EDGE_LO];
    end

    // Set beats clear in the same cycle
    n.ctl[CTL_DONE_BIT] = (q.ctl[CTL_DONE_BIT] &
      !(conv_vec_ack || (wr_ctl && wdata[CTL_DONE_BIT]))) | conv_evt;
    n.cmp[CMP_FLAG_BIT] = (q.cmp[CMP_FLAG_BIT] &
      !(cmp_vec_ack || (wr_cmp && wdata[CMP_FLAG_BIT]))) | cmp_evt;

    n.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        RESULT_LOW_OFS: n.rdata = align(q.res, q.chan[CHAN_LEFT_BIT],
                                        1'b0);
        RESULT_HIGH_OFS: n.rdata = align(q.res, q.chan[CHAN_LEFT_BIT],
                                         1'b1);
        CONV_CTRL_OFS: n.rdata = q.ctl;
        CHAN_SEL_OFS: n.rdata = q.chan;
        CMP_CTRL_OFS: begin
          n.rdata = q.cmp;
          n.rdata[CMP_OUT_BIT] = q.s2;
        end
        default: n.rdata = 8'h00;
      endcase
      if (addr == RESULT_LOW_OFS) begin
        n.lock = 1'b1;
      end else if (addr == RESULT_HIGH_OFS) begin
        n.lock = 1'b0;
      end
    end

    n.cmp_irq = n.cmp[CMP_FLAG_BIT] & n.cmp[CMP_IE_BIT] & gie;
    n.conv_irq = n.ctl[CTL_DONE_BIT] & n.ctl[CTL_IE_BIT] & gie;
    // Built from next values so the mux follows one cycle after a write
    n.neg_mux = n.cmp[CMP_MUX_BIT] & !n.ctl[CTL_EN_BIT];
    n.neg_chan = n.chan[CHAN_LOW_HI:0];
    n.pcblk = !n.cmp[CMP_OFF_BIT];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ctl <= CTL_RESET;
      q.chan <= CHAN_RESET;
      q.cmp <= CMP_RESET;
    end else begin
      q <= n;
    end
  end

  assign rdata = q.rdata;
  assign cmp_irq = q.cmp_irq;
  assign conv_irq = q.conv_irq;
  assign cmp_power_off = q.cmp[CMP_OFF_BIT];
  assign cmp_bandgap = q.cmp[CMP_BG_BIT];
  assign cmp_neg_from_mux = q.neg_mux;
  assign cmp_neg_chan = q.neg_chan;
  assign pin_change_block = q.pcblk;
  assign conv_power = q.ctl[CTL_EN_BIT];
  assign conv_chan = q.chan_buf;
  assign conv_ref = q.ref_buf;
  assign sample_hold = q.sh;
  assign conv_busy = q.busy;
  assign conv_done = q.done;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence low_read;
    rd && addr == RESULT_LOW_OFS;
  endsequence

  sequence done_step;
    q.busy && rise && last;
  endsequence

  out_bit_live_a: assert property (
    rd && addr == CMP_CTRL_OFS |=> rdata[CMP_OUT_BIT] == $past(q.s2))
    else $error("comparator output bit stale");

  rise_flag_a: assert property (
    !q.cmp[CMP_OFF_BIT] && q.cmp[1:0] == EDGE_RISE && q.s2 && !q.prev
    |=> q.cmp[CMP_FLAG_BIT])
    else $error("rising edge did not set flag");

  irq_gate_a: assert property (
    cmp_irq |-> q.cmp[CMP_FLAG_BIT] && q.cmp[CMP_IE_BIT] && $past(gie))
    else $error("comparator irq without flag and enable");

  vec_clear_a: assert property (
    cmp_vec_ack && !cmp_evt |=> !q.cmp[CMP_FLAG_BIT])
    else $error("flag not cleared by vector");

  reserved_mode_a: assert property (
    q.cmp[1:0] == EDGE_RESERVED && !q.cmp[CMP_FLAG_BIT] && !wr_cmp
    |=> !q.cmp[CMP_FLAG_BIT])
    else $error("reserved mode raised flag");

  mux_follow_a: assert property (
    wr && addr == CHAN_SEL_OFS |=> cmp_neg_chan == $past(wdata[3:0]))
    else $error("comparator channel not applied");

  pin_block_a: assert property (
    wr_cmp |=> pin_change_block == !$past(wdata[CMP_OFF_BIT]))
    else $error("pin-change block wrong");

  conv_length_a: assert property (
    q.busy |-> q.cyc < conv_len(q.warm))
    else $error("conversion overran its length");

  single_done_a: assert property (
    done_step ##0 (!q.ctl[CTL_FREE_BIT] && !wr_ctl)
    |=> conv_done && !q.ctl[CTL_START_BIT] && !conv_busy)
    else $error("single conversion did not finish cleanly");

  lock_keep_a: assert property (
    done_step ##0 q.lock |=> $stable(q.res))
    else $error("locked result was overwritten");

  lock_set_a: assert property (
    low_read |=> q.lock)
    else $error("low result read did not lock");

  done_flag_a: assert property (
    done_step |=> q.ctl[CTL_DONE_BIT] && conv_done)
    else $error("done flag missing");

  prescaler_idle_a: assert property (
    !q.ctl[CTL_EN_BIT] ##1 !q.ctl[CTL_EN_BIT] |-> !rise && !fall)
    else $error("prescaler ran while disabled");
endmodule

// File: tb/test_adc_and_comparator_control.sv
// Self-checking bench for the converter and comparator control block
`timescale 1ns/100ps
module test_adc_and_comparator_control;
  import adc_cmp_pkg::*;
  typedef struct packed {logic [7:0] v; logic [7:0] m;} note_t;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic gie = 1'b0, cmp_vec_ack = 1'b0, conv_vec_ack = 1'b0;
  logic cmp_raw = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [9:0] conv_data = 10'h000, dat, old;
  logic cmp_irq, conv_irq, cmp_power_off, cmp_bandgap, cmp_neg_from_mux;
  logic pin_change_block, conv_power, conv_clk, sample_hold, conv_busy;
  logic conv_done;
  logic [3:0] cmp_neg_chan;
  logic [4:0] conv_chan;
  logic [1:0] conv_ref;
  note_t notes[$];
  note_t nt;
  int error_cnt = 0, cmp_count = 0, seed = 73326, td, ts, per;

  always #4 clk = ~clk;

  adc_cmp_ctrl adc_cmp_ctrl_i (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gie(gie),
    .cmp_vec_ack(cmp_vec_ack), .conv_vec_ack(conv_vec_ack),
    .cmp_raw(cmp_raw), .conv_data(conv_data), .cmp_irq(cmp_irq),
    .conv_irq(conv_irq), .cmp_power_off(cmp_power_off),
    .cmp_bandgap(cmp_bandgap), .cmp_neg_from_mux(cmp_neg_from_mux),
    .cmp_neg_chan(cmp_neg_chan), .pin_change_block(pin_change_block),
    .conv_power(conv_power), .conv_clk(conv_clk), .conv_chan(conv_chan),
    .conv_ref(conv_ref), .sample_hold(sample_hold), .conv_busy(conv_busy),
    .conv_done(conv_done));

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic in_range(input int v, input int lo, input int hi);
    check(8'(v >= lo && v <= hi), 8'h01);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Expectation is noted here, compared by the read monitor
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] v,
                        input logic [7:0] m);
    @(posedge clk);
    notes.push_back('{v, m});
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic set_data(input logic [9:0] d);
    @(posedge clk);
    dat = d;
    conv_data <= d;
  endtask

  // Cycles from busy to done, and from busy to the sample strobe
  task automatic conv_wait(output int n, output int s);
    int k;
    for (k = 0; k < 600 && conv_busy !== 1'b1; k++) step(1);
    n = 0;
    s = 0;
    do begin
      step(1);
      n++;
      if (sample_hold === 1'b1) s = n;
    end while (conv_done !== 1'b1 && n < 600);
  endtask

  task automatic period(output int n);
    int k;
    for (k = 0; k < 300 && conv_clk !== 1'b1; k++) step(1);
    for (k = 0; k < 300 && conv_clk !== 1'b0; k++) step(1);
    for (n = k; n < 600 && conv_clk !== 1'b1; n++) step(1);
  endtask

  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d && notes.size() > 0) begin
      nt = notes.pop_front();
      check(rdata & nt.m, nt.v);
    end
  end

  initial begin
    #(8 * 40000);
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    step(2);
    check(8'(pin_change_block), 8'h01);
    check(8'(conv_clk), 8'h00);
    rd_reg(CONV_CTRL_OFS, CTL_RESET, 8'hff);
    rd_reg(CHAN_SEL_OFS, CHAN_RESET, 8'hff);
    rd_reg(CMP_CTRL_OFS, CMP_RESET, 8'hff);
    wr_reg(8'h00, 8'hff);
    rd_reg(8'h00, 8'h00, 8'hff);
    wr_reg(CMP_CTRL_OFS, 8'hc0);
    step(2);
    check(8'(pin_change_block), 8'h00);
    check(8'(cmp_power_off), 8'h01);
    check(8'(cmp_bandgap), 8'h01);
    // Output bit is read-only, so the written one must not show
    wr_reg(CMP_CTRL_OFS, 8'h24);
    rd_reg(CMP_CTRL_OFS, 8'h04, 8'hff);
    for (int k = 0; k < 16; k++) begin
      wr_reg(CHAN_SEL_OFS, 8'h10 | 8'(k));
      step(1);
      check(8'(cmp_neg_from_mux), 8'h01);
      check(8'(cmp_neg_chan), 8'(k));
    end
    check(8'(conv_chan), 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr_reg(CMP_CTRL_OFS, 8'h10 | 8'(m));
      cmp_raw <= 1'b1;
      step(8);
      rd_reg(CMP_CTRL_OFS, {3'b001, m == 0 || m == 3, 4'h0}, 8'h30);
      wr_reg(CMP_CTRL_OFS, 8'h10 | 8'(m));
      cmp_raw <= 1'b0;
      step(8);
      rd_reg(CMP_CTRL_OFS, {3'b000, m == 0 || m == 2, 4'h0}, 8'h30);
    end
    wr_reg(CMP_CTRL_OFS, 8'h10);
    wr_reg(CMP_CTRL_OFS, 8'h18);
    gie <= 1'b1;
    cmp_raw <= 1'b1;
    step(8);
    check(8'(cmp_irq), 8'h01);
    @(posedge clk);
    gie <= 1'b0;
    step(2);
    check(8'(cmp_irq), 8'h00);
    @(posedge clk);
    gie <= 1'b1;
    cmp_vec_ack <= 1'b1;
    @(posedge clk);
    cmp_vec_ack <= 1'b0;
    step(2);
    check(8'(cmp_irq), 8'h00);
    rd_reg(CMP_CTRL_OFS, 8'h00, 8'h10);
    cmp_raw <= 1'b0;
    step(8);
    wr_reg(CMP_CTRL_OFS, 8'h08);
    step(2);
    check(8'(cmp_irq), 8'h01);
    wr_reg(CMP_CTRL_OFS, 8'h1c);
    step(2);
    check(8'(cmp_irq), 8'h00);
    // Converter: first conversion after enable is the long one
    wr_reg(CHAN_SEL_OFS, 8'h03);
    step(3);
    check(8'(conv_chan), 8'h00);
    set_data(10'($random(seed)));
    wr_reg(CONV_CTRL_OFS, 8'hc8);
    conv_wait(td, ts);
    in_range(td, 46, 54);
    in_range(ts, 24, 30);
    check(8'(conv_power), 8'h01);
    check(8'(cmp_neg_from_mux), 8'h00);
    step(2);
    rd_reg(CONV_CTRL_OFS, 8'h98, 8'hff);
    check(8'(conv_irq), 8'h01);
    @(posedge clk);
    conv_vec_ack <= 1'b1;
    @(posedge clk);
    conv_vec_ack <= 1'b0;
    step(2);
    check(8'(conv_irq), 8'h00);
    rd_reg(RESULT_LOW_OFS, dat[7:0], 8'hff);
    rd_reg(RESULT_HIGH_OFS, {6'h00, dat[9:8]}, 8'hff);
    wr_reg(CHAN_SEL_OFS, 8'h23);
    rd_reg(RESULT_LOW_OFS, {dat[1:0], 6'h00}, 8'hff);
    rd_reg(RESULT_HIGH_OFS, dat[9:2], 8'hff);
    wr_reg(CHAN_SEL_OFS, 8'h03);
    // Low read locks; the next result is dropped but still flagged
    rd_reg(RESULT_LOW_OFS, dat[7:0], 8'hff);
    old = dat;
    set_data(old ^ 10'h3ff);
    wr_reg(CONV_CTRL_OFS, 8'hc8);
    conv_wait(td, ts);
    in_range(td, 23, 29);
    in_range(ts, 1, 5);
    step(2);
    rd_reg(CONV_CTRL_OFS, 8'h10, 8'h50);
    rd_reg(RESULT_HIGH_OFS, {6'h00, old[9:8]}, 8'hff);
    rd_reg(RESULT_LOW_OFS, old[7:0], 8'hff);
    rd_reg(RESULT_HIGH_OFS, {6'h00, old[9:8]}, 8'hff);
    // Free run with a channel change in mid-conversion
    wr_reg(CONV_CTRL_OFS, 8'hf8);
    step(6);
    wr_reg(CHAN_SEL_OFS, 8'hc5);
    step(2);
    check(8'(conv_chan), 8'h03);
    check(8'(conv_ref), 8'h00);
    conv_wait(td, ts);
    set_data(10'($random(seed)));
    conv_wait(td, ts);
    in_range(td, 22, 30);
    step(2);
    check(8'(conv_chan), 8'h05);
    check(8'(conv_ref), 8'h03);
    rd_reg(CONV_CTRL_OFS, 8'h60, 8'h60);
    rd_reg(RESULT_LOW_OFS, dat[7:0], 8'hff);
    rd_reg(RESULT_HIGH_OFS, {6'h00, dat[9:8]}, 8'hff);
    // Differential pair: the second rise after enable may not start
    wr_reg(CONV_CTRL_OFS, 8'h00);
    wr_reg(CHAN_SEL_OFS, 8'h0b);
    wr_reg(CONV_CTRL_OFS, 8'h87);
    step(200);
    wr_reg(CONV_CTRL_OFS, 8'hc7);
    for (td = 0; td < 600 && conv_busy !== 1'b1; td++) step(1);
    in_range(td, 129, 256);
    // Prescaler ratios; counter held while the converter is off
    for (int p = 0; p < 8; p++) begin
      wr_reg(CONV_CTRL_OFS, 8'h00);
      step(300);
      check(8'(conv_clk), 8'h00);
      check(8'(conv_power), 8'h00);
      wr_reg(CONV_CTRL_OFS, 8'h80 | 8'(p));
      period(per);
      period(per);
      in_range(per, p < 2 ? 2 : 1 << p, p < 2 ? 2 : 1 << p);
    end
    step(4);
    summarize();
  end
endmodule
